// ===== bench/modulo_counter_with_capture_test.sv
// Purpose: self-checking bench of the modulo counter with capture
// Assumes: design answers every bus request within the watchdog span
// Notes:   prescaled counts judged within a window, as bus latency adds cycles
`timescale 1ns/1ps
module modulo_counter_with_capture_test;
  import modulo_timer_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, irq, ext, go, busy;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0]   wdata, rdata;
  logic [1:0]    bresp, rresp, rsp;
  logic [3:0]    lvl, pins;
  logic [7:0]    rv, n;
  logic [15:0]   cnt;
  int            bad_count, cmp_count;
  modulo_counter_with_capture #(.NCH(4)) dut (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(4'h1), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .external_count_clock(ext), .capture_pin(pins), .overflow_irq(irq));
  pin_source #(.NCH(4)) src (.aclk(aclk), .go(go), .n(n), .level_req(lvl),
    .ext_clk(ext), .busy(busy), .cap_pin(pins));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] g);
    cmp_count++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      bad_count++;
      $display("MISMATCH %s expected %0d..%0d seen %0d", nm, lo, hi, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do @(posedge aclk); while (awready !== 1'b1 || wready !== 1'b1);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    do @(posedge aclk); while (bvalid !== 1'b1);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rv = rdata[7:0];
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rcnt;
    rd(OFF_CNT_HI);
    cnt[15:8] = rv;
    rd(OFF_CNT_LO);
    cnt[7:0] = rv;
  endtask
  task automatic wirq(input int lim);
    int k = 0;
    while (irq !== 1'b1 && k < lim) begin
      @(posedge aclk);
      k++;
    end
  endtask
  task automatic setmod(input logic [15:0] m);
    wr(OFF_STATUS, 8'h30);
    wr(OFF_MOD_HI, m[15:8]);
    wr(OFF_MOD_LO, m[7:0]);
  endtask
  task automatic t_reset;
    rd(OFF_STATUS);
    chk("status", 8'h20, rv);
    rd(OFF_MOD_HI);
    chk("mod hi", 8'hff, rv);
    rcnt;
    chk("count", 16'h0, cnt);
    wr(OFF_CNT_LO, 8'h55);
    chk("count write resp", RESP_SLVERR, rsp);
    rd(8'h3c);
    chk("unmapped resp", RESP_SLVERR, rsp);
    chk("irq", 1'b0, irq);
    $display("test reset done");
  endtask
  task automatic t_overflow;
    setmod(16'h0005);
    rcnt;
    chk("count", 16'h0, cnt);
    rd(OFF_MOD_LO);
    chk("mod lo", 8'h05, rv);
    wr(OFF_STATUS, 8'h40);
    wirq(40);
    chk("irq", 1'b1, irq);
    wr(OFF_STATUS, 8'h60);
    rcnt;
    chk_rng("count", 0, 5, cnt);
    rd(OFF_STATUS);
    chk("status", 8'he0, rv);
    wr(OFF_STATUS, 8'h60);
    rd(OFF_STATUS);
    chk("status", 8'h60, rv);
    chk("irq", 1'b0, irq);
    setmod(16'h0001);
    wr(OFF_STATUS, 8'h00);
    rd(OFF_STATUS);
    wr(OFF_STATUS, 8'h20);
    rd(OFF_STATUS);
    chk("status", 8'ha0, rv);
    $display("test overflow done");
  endtask
  task automatic t_presc;
    logic [15:0] v;
    setmod(16'hffff);
    for (int k = 0; k < 7; k++) begin
      wr(OFF_STATUS, 8'h30 | 8'(k));
      wr(OFF_STATUS, 8'(k));
      repeat (640) @(posedge aclk);
      wr(OFF_STATUS, 8'h20 | 8'(k));
      rcnt;
      chk_rng("prescaled count", 640 >> k, (652 >> k) + 1, cnt);
    end
    v = cnt;
    rcnt;
    chk("reread count", v, cnt);
    wr(OFF_STATUS, 8'h37);
    wr(OFF_STATUS, 8'h07);
    n  <= 8'd10;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    @(posedge aclk);
    while (busy) @(posedge aclk);
    repeat (6) @(posedge aclk);
    wr(OFF_STATUS, 8'h27);
    rcnt;
    chk("external count", 16'd10, cnt);
    $display("test prescaler done");
  endtask
  task automatic t_reset_bit;
    logic [7:0] l;
    wr(OFF_STATUS, 8'h00);
    repeat (200) @(posedge aclk);
    wr(OFF_STATUS, 8'h10);
    rd(OFF_STATUS);
    chk("status", 8'h00, rv);
    rcnt;
    chk_rng("count", 0, 20, cnt);
    rd(OFF_CNT_HI);
    wr(OFF_STATUS, 8'h20);
    rd(OFF_CNT_HI);
    rd(OFF_CNT_LO);
    l = rv;
    rd(OFF_CNT_LO);
    chk_rng("frozen low lag", 2, 30, 16'(rv - l));
    $display("test counter reset done");
  endtask
  task automatic t_pending;
    setmod(16'h0002);
    wr(OFF_MOD_HI, 8'h00);
    wr(OFF_STATUS, 8'h40);
    repeat (60) @(posedge aclk);
    chk("irq", 1'b0, irq);
    rd(OFF_STATUS);
    chk("status", 8'h40, rv);
    wr(OFF_MOD_LO, 8'h02);
    wirq(20);
    chk("irq", 1'b1, irq);
    wr(OFF_STATUS, 8'h60);
    rd(OFF_STATUS);
    wr(OFF_STATUS, 8'h20);
    setmod(16'h0000);
    wr(OFF_STATUS, 8'h00);
    repeat (10) @(posedge aclk);
    rd(OFF_STATUS);
    chk("zero mod status", 8'h80, rv);
    wr(OFF_STATUS, 8'h00);
    repeat (10) @(posedge aclk);
    rd(OFF_STATUS);
    chk("zero mod repeat", 8'h00, rv);
    $display("test modulo pending done");
  endtask
  task automatic t_capture;
    logic [1:0]  ed [4] = '{EDGE_RISE, EDGE_FALL, EDGE_ANY, EDGE_OFF};
    logic [15:0] e [4];
    setmod(16'hffff);
    for (int c = 0; c < 4; c++) begin
      wr(OFF_CH_BASE + CH_STRIDE * 8'(c), {4'h0, ed[c], 2'h0});
      rd(OFF_CH_BASE + CH_STRIDE * 8'(c));
      chk("edge field", {4'h0, ed[c], 2'h0}, rv);
    end
    wr(OFF_STATUS, 8'h00);
    repeat (37) @(posedge aclk);
    wr(OFF_STATUS, 8'h20);
    rcnt;
    e[0] = cnt;
    lvl <= 4'hf;
    repeat (8) @(posedge aclk);
    wr(OFF_STATUS, 8'h00);
    repeat (20) @(posedge aclk);
    wr(OFF_STATUS, 8'h20);
    rcnt;
    e[1] = cnt;
    e[2] = cnt;
    e[3] = 16'h0;
    lvl <= 4'h0;
    repeat (8) @(posedge aclk);
    for (int c = 0; c < 4; c++) begin
      rd(OFF_CAP_BASE + CAP_STRIDE * 8'(c));
      cnt[15:8] = rv;
      rd(OFF_CAP_BASE + CAP_STRIDE * 8'(c) + CAP_LO_OFS);
      cnt[7:0] = rv;
      chk("capture", e[c], cnt);
    end
    $display("test capture done");
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    results;
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
    {awaddr, araddr, wdata, n, lvl} = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_overflow;
    t_presc;
    t_reset_bit;
    t_pending;
    t_capture;
    results;
  end
endmodule

// ===== bench/pin_source.sv
// Purpose: far-side model driving the external count clock and capture pins
// Assumes: bench asks for a burst of clock pulses and for capture levels
// Notes:   each level held three bus clocks, over the one-clock minimum
`timescale 1ns/1ps
module pin_source #(
  parameter int NCH = 4
) (
  input  wire logic           aclk,
  input  wire logic           go,
  input  wire logic [7:0]     n,
  input  wire logic [NCH-1:0] level_req,
  output logic                ext_clk,
  output logic                busy,
  output logic [NCH-1:0]      cap_pin
);
  assign cap_pin = level_req;
  // clock idles low between bursts, it does not run free
  initial begin
    ext_clk = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge aclk);
      if (go) begin
        busy <= 1'b1;
        repeat (n) begin
          repeat (3) @(posedge aclk);
          ext_clk <= 1'b1;
          repeat (3) @(posedge aclk);
          ext_clk <= 1'b0;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule

// ===== design/modulo_counter_with_capture.sv
// Purpose: 16-bit modulo counter, prescaler, overflow flag, input capture
// Assumes: one bus clock aclk, synchronous active-low aresetn
// Notes:   pins pass two flops before use; capture flags not included
`timescale 1ns/1ps
// Function
// - clock_select picks bus clock, divide by 2..64, or synced external clock.
// - changing selection while running may add one extra count.
// - reset halts the counter and selects the undivided bus clock.
// - clearing the halt after reset counts up from zero.
// - match with modulo sets overflow flag; next count returns to zero.
// - interrupt request while overflow flag and enable set and no modulo low write pending; reset clears enable.
// - flag clears only by status read with flag set then zero write.
// - overflow between that read and write keeps the flag set.
// - halt bit is read/write, holds counter, reset sets it.
// - halt gates the prescaler so its phase is kept.
// - counter-reset bit clears counter and prescaler, reads zero.
// - halt plus counter-reset in one write leaves counter at zero.
// - count bytes are read-only, reads never disturb, reset gives zero.
// - high byte read freezes low copy until low byte read.
// - modulo high write suppresses overflow until modulo low written.
// - modulo is read/write and resets to all ones.
// - modulo zero sets flag only on first match cycle.
// - each channel latches the counter on its selected pin event, except between its capture high byte read and low byte read.
// - each channel selects rising, falling, either edge, or disabled.
// - edge field 00 off, 01 rising, 10 falling, 11 either.
// - channels are independent and may capture the same value.
module modulo_counter_with_capture
  import modulo_timer_pkg::*;
#(
  parameter int NCH = 4
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [AW-1:0]    awaddr,
  input  wire logic [2:0]       awprot,
  input  wire logic             awvalid,
  output logic                  awready,
  input  wire logic [31:0]      wdata,
  input  wire logic [3:0]       wstrb,
  input  wire logic             wvalid,
  output logic                  wready,
  output logic [1:0]            bresp,
  output logic                  bvalid,
  input  wire logic             bready,
  input  wire logic [AW-1:0]    araddr,
  input  wire logic [2:0]       arprot,
  input  wire logic             arvalid,
  output logic                  arready,
  output logic [31:0]           rdata,
  output logic [1:0]            rresp,
  output logic                  rvalid,
  input  wire logic             rready,
  input  wire logic             external_count_clock,
  input  wire logic [NCH-1:0]   capture_pin,
  output logic                  overflow_irq
);

  function automatic logic tap_hit(input logic [2:0] sel, input logic [PRESC_W-1:0] p);
    logic [PRESC_W-1:0] mask;
    mask = PRESC_W'((7'h1 << sel) - 7'h1);
    return &(p | ~mask);
  endfunction

  function automatic logic edge_hit(input logic [1:0] mode, input logic now, input logic was);
    logic rise;
    logic fall;
    rise = now && !was;
    fall = !now && was;
    case (mode)
      EDGE_RISE: return rise;
      EDGE_FALL: return fall;
      EDGE_ANY:  return rise || fall;
      default:   return 1'b0;
    endcase
  endfunction

  logic               awready_r, awready_nxt;
  logic               bvalid_r, bvalid_nxt;
  logic [1:0]         bresp_r, bresp_nxt;
  logic               arready_r, arready_nxt;
  logic               rvalid_r, rvalid_nxt;
  logic [31:0]        rdata_r, rdata_nxt;
  logic [1:0]         rresp_r, rresp_nxt;
  logic               aw_take, ar_take;
  logic               wr_hit, rd_hit;
  logic [7:0]         rd_byte;

  logic [2:0]         sel_r, sel_nxt;
  logic               halt_r, halt_nxt;
  logic               ie_r, ie_nxt;
  logic               flag_r, flag_nxt;
  logic               armed_r, armed_nxt;
  logic [PRESC_W-1:0] presc_r, presc_nxt;
  logic [15:0]        cnt_r, cnt_nxt;
  logic [15:0]        mod_r, mod_nxt;
  logic               mod_pend_r, mod_pend_nxt;
  logic               zhit_r, zhit_nxt;
  logic [7:0]         lat_lo_r, lat_lo_nxt;
  logic               lat_v_r, lat_v_nxt;
  logic               irq_r, irq_nxt;
  logic [1:0]         edge_r [NCH];
  logic [1:0]         edge_nxt [NCH];
  logic [15:0]        cap_r [NCH];
  logic [15:0]        cap_nxt [NCH];
  logic [NCH-1:0]     inhib_r, inhib_nxt;
  logic [NCH-1:0]     cap_ev;

  logic               ext_s1, ext_s2, ext_s3;
  logic [NCH-1:0]     pin_s1, pin_s2, pin_s3;
  logic               tick, ov_set, crst, wr, rd;
  logic [15:0]        cnt_step;
  logic [7:0]         wa, ra, wd;

  assign awready      = awready_r;
  assign wready       = awready_r;
  assign bvalid       = bvalid_r;
  assign bresp        = bresp_r;
  assign arready      = arready_r;
  assign rvalid       = rvalid_r;
  assign rdata        = rdata_r;
  assign rresp        = rresp_r;
  assign overflow_irq = irq_r;

  // pin synchronisers; stage one feeds only stage two
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
    end else begin
      ext_s1 <= external_count_clock;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      pin_s1 <= capture_pin;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  assign wa = awaddr;
  assign ra = araddr;
  assign wd = wdata[7:0];
  assign aw_take = awready_r && awvalid && wvalid;
  assign ar_take = arready_r && arvalid;
  assign wr = aw_take && wstrb[0] && wr_hit;
  assign rd = ar_take && rd_hit;

  // address decode and read mux
  always_comb begin
    rd_hit  = 1'b1;
    rd_byte = 8'h00;
    wr_hit  = (wa == OFF_STATUS) || (wa == OFF_MOD_HI) || (wa == OFF_MOD_LO);
    case (ra)
      OFF_STATUS: rd_byte = {flag_r, ie_r, halt_r, 2'h0, sel_r};
      OFF_CNT_HI: rd_byte = cnt_r[15:8];
      OFF_CNT_LO: rd_byte = lat_v_r ? lat_lo_r : cnt_r[7:0];
      OFF_MOD_HI: rd_byte = mod_r[15:8];
      OFF_MOD_LO: rd_byte = mod_r[7:0];
      default:    rd_hit  = 1'b0;
    endcase
    for (int c = 0; c < NCH; c++) begin
      if (wa == OFF_CH_BASE + 8'(c) * CH_STRIDE) begin
        wr_hit = 1'b1;
      end
      if (ra == OFF_CH_BASE + 8'(c) * CH_STRIDE) begin
        rd_hit  = 1'b1;
        rd_byte = {4'h0, edge_r[c], 2'h0};
      end
      if (ra == OFF_CAP_BASE + 8'(c) * CAP_STRIDE) begin
        rd_hit  = 1'b1;
        rd_byte = cap_r[c][15:8];
      end
      if (ra == OFF_CAP_BASE + 8'(c) * CAP_STRIDE + CAP_LO_OFS) begin
        rd_hit  = 1'b1;
        rd_byte = cap_r[c][7:0];
      end
    end
  end

  // bus handshake; write address and data are taken together
  always_comb begin
    awready_nxt = !awready_r && awvalid && wvalid && !bvalid_r;
    bvalid_nxt  = aw_take || (bvalid_r && !bready);
    bresp_nxt   = aw_take ? (wr_hit ? RESP_OKAY : RESP_SLVERR) : bresp_r;
    arready_nxt = !arready_r && arvalid && !rvalid_r;
    rvalid_nxt  = ar_take || (rvalid_r && !rready);
    rdata_nxt   = ar_take ? {24'h0, rd_byte} : rdata_r;
    rresp_nxt   = ar_take ? (rd_hit ? RESP_OKAY : RESP_SLVERR) : rresp_r;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0;
      rresp_r   <= RESP_OKAY;
    end else begin
      awready_r <= awready_nxt;
      bvalid_r  <= bvalid_nxt;
      bresp_r   <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r  <= rvalid_nxt;
      rdata_r   <= rdata_nxt;
      rresp_r   <= rresp_nxt;
    end
  end

  // a switch of clock_select may land on a high tap and count once more
  assign tick = !halt_r && (sel_r == SEL_EXT ? (ext_s2 && !ext_s3) : tap_hit(sel_r, presc_r));
  assign cnt_step = (cnt_r == mod_r) ? 16'h0 : cnt_r + 16'h1;
  // modulo zero flags on its first match only; zhit_r blocks the repeats
  assign ov_set = tick && !mod_pend_r && ((cnt_step == mod_r && cnt_r != mod_r) ||
                  (cnt_r == 16'h0 && mod_r == 16'h0 && !zhit_r));
  assign crst = wr && wa == OFF_STATUS && wd[BIT_CRST];

  always_comb begin
    sel_nxt      = sel_r;
    halt_nxt     = halt_r;
    ie_nxt       = ie_r;
    flag_nxt     = flag_r;
    armed_nxt    = armed_r;
    presc_nxt    = halt_r ? presc_r : presc_r + PRESC_W'(1);
    cnt_nxt      = tick ? cnt_step : cnt_r;
    mod_nxt      = mod_r;
    mod_pend_nxt = mod_pend_r;
    lat_lo_nxt   = lat_lo_r;
    lat_v_nxt    = lat_v_r;
    inhib_nxt    = inhib_r;
    for (int c = 0; c < NCH; c++) begin
      edge_nxt[c] = edge_r[c];
      cap_nxt[c]  = cap_r[c];
      cap_ev[c]   = edge_hit(edge_r[c], pin_s2[c], pin_s3[c]);
      if (cap_ev[c] && !inhib_r[c]) begin
        cap_nxt[c] = cnt_r;
      end
      if (wr && wa == OFF_CH_BASE + 8'(c) * CH_STRIDE) begin
        edge_nxt[c] = wd[EDGE_LSB+1:EDGE_LSB];
      end
      if (rd && ra == OFF_CAP_BASE + 8'(c) * CAP_STRIDE) begin
        inhib_nxt[c] = 1'b1;
      end
      if (rd && ra == OFF_CAP_BASE + 8'(c) * CAP_STRIDE + CAP_LO_OFS) begin
        inhib_nxt[c] = 1'b0;
      end
    end
    if (rd && ra == OFF_STATUS && flag_r) begin
      armed_nxt = 1'b1;
    end
    if (wr && wa == OFF_STATUS) begin
      ie_nxt   = wd[BIT_IE];
      halt_nxt = wd[BIT_HALT];
      sel_nxt  = wd[SEL_MSB:0];
      if (!wd[BIT_FLAG] && armed_r) begin
        flag_nxt = 1'b0;
      end
      armed_nxt = 1'b0;
    end
    if (rd && ra == OFF_CNT_HI && !lat_v_r) begin
      lat_lo_nxt = cnt_r[7:0];
      lat_v_nxt  = 1'b1;
    end
    if (rd && ra == OFF_CNT_LO) begin
      lat_v_nxt = 1'b0;
    end
    if (wr && wa == OFF_MOD_HI) begin
      mod_nxt[15:8] = wd;
      mod_pend_nxt  = 1'b1;
    end
    if (wr && wa == OFF_MOD_LO) begin
      mod_nxt[7:0] = wd;
      mod_pend_nxt = 1'b0;
    end
    if (crst) begin
      cnt_nxt   = 16'h0;
      presc_nxt = '0;
      lat_v_nxt = 1'b0;
    end
    // set wins over a pending clear
    if (ov_set) begin
      flag_nxt  = 1'b1;
      armed_nxt = 1'b0;
    end
    irq_nxt = flag_nxt && ie_nxt && !mod_pend_nxt;
    zhit_nxt = (zhit_r || ov_set) && !crst && !(wr && (wa == OFF_MOD_HI || wa == OFF_MOD_LO));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sel_r      <= SEL_RESET;
      halt_r     <= HALT_RESET;
      ie_r       <= 1'b0;
      flag_r     <= 1'b0;
      armed_r    <= 1'b0;
      presc_r    <= '0;
      cnt_r      <= 16'h0;
      mod_r      <= MOD_RESET;
      mod_pend_r <= 1'b0;
      zhit_r     <= 1'b0;
      lat_lo_r   <= 8'h0;
      lat_v_r    <= 1'b0;
      irq_r      <= 1'b0;
      inhib_r    <= '0;
      for (int c = 0; c < NCH; c++) begin
        edge_r[c] <= EDGE_OFF;
        cap_r[c]  <= 16'h0;
      end
    end else begin
      sel_r      <= sel_nxt;
      halt_r     <= halt_nxt;
      ie_r       <= ie_nxt;
      flag_r     <= flag_nxt;
      armed_r    <= armed_nxt;
      presc_r    <= presc_nxt;
      cnt_r      <= cnt_nxt;
      mod_r      <= mod_nxt;
      mod_pend_r <= mod_pend_nxt;
      zhit_r     <= zhit_nxt;
      lat_lo_r   <= lat_lo_nxt;
      lat_v_r    <= lat_v_nxt;
      irq_r      <= irq_nxt;
      inhib_r    <= inhib_nxt;
      for (int c = 0; c < NCH; c++) begin
        edge_r[c] <= edge_nxt[c];
        cap_r[c]  <= cap_nxt[c];
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  reset_state_a: assert property (disable iff (1'b0) $rose(aresetn) |-> halt_r && sel_r == 3'h0 && cnt_r == 16'h0)
    else $error("reset state wrong");
  mod_reset_a: assert property (disable iff (1'b0) $rose(aresetn) |-> mod_r == 16'hffff && !ie_r)
    else $error("modulo or enable reset wrong");
  halt_holds_a: assert property (halt_r && !crst |=> cnt_r == $past(cnt_r) && presc_r == $past(presc_r))
    else $error("counter moved while halted");
  wrap_zero_a: assert property (tick && !crst && cnt_r == mod_r |=> cnt_r == 16'h0)
    else $error("no wrap to zero");
  flag_set_a: assert property (tick && cnt_r + 16'h1 == mod_r && !mod_pend_r |=> flag_r)
    else $error("overflow flag not set");
  irq_level_a: assert property (irq_r == (flag_r && ie_r && !mod_pend_r))
    else $error("irq level wrong");
  no_clear_a: assert property (flag_r && !armed_r |=> flag_r)
    else $error("flag cleared without read");
  set_wins_a: assert property (ov_set |=> flag_r)
    else $error("overflow lost");
  count_reset_a: assert property (crst |=> cnt_r == 16'h0 && presc_r == '0)
    else $error("counter reset failed");
  stop_zero_a: assert property (crst && wd[BIT_HALT] |=> (cnt_r == 16'h0 && halt_r)[*2])
    else $error("not halted at zero");
  latch_copy_a: assert property (rd && ra == OFF_CNT_HI && !lat_v_r |=> lat_lo_r == $past(cnt_r[7:0]))
    else $error("low byte copy wrong");
  pend_block_a: assert property (mod_pend_r |-> !ov_set)
    else $error("overflow during modulo update");
  zero_once_a: assert property (ov_set && mod_r == 16'h0 && !wr |=> !ov_set)
    else $error("repeat overflow at modulo zero");
  zero_first_a: assert property (tick && cnt_r == 16'h0 && mod_r == 16'h0 && !mod_pend_r && !zhit_r |=> flag_r)
    else $error("first modulo zero match not flagged");
  capture_a: assert property (cap_ev[0] && !inhib_r[0] |=> cap_r[0] == $past(cnt_r))
    else $error("capture value wrong");

  ov_cover_c: cover property (ov_set ##1 flag_r && irq_r);
  clear_cover_c: cover property (armed_r ##[1:20] !flag_r);
  cap_cover_c: cover property (cap_ev[0] && cap_ev[1] && !inhib_r[0] && !inhib_r[1]);
  ext_cover_c: cover property (sel_r == SEL_EXT && tick);

endmodule

// ===== design/modulo_timer_pkg.sv
// Purpose: shared constants of the modulo counter with capture
// Assumes: axi4-lite slave, 32-bit data, byte registers in the low bits
// Notes:   offsets are byte addresses
package modulo_timer_pkg;
  localparam int          AW            = 8;
  localparam logic [7:0]  OFF_STATUS    = 8'h00;
  localparam logic [7:0]  OFF_CNT_HI    = 8'h04;
  localparam logic [7:0]  OFF_CNT_LO    = 8'h08;
  localparam logic [7:0]  OFF_MOD_HI    = 8'h0c;
  localparam logic [7:0]  OFF_MOD_LO    = 8'h10;
  localparam logic [7:0]  OFF_CH_BASE   = 8'h20;
  localparam logic [7:0]  OFF_CAP_BASE  = 8'h40;
  localparam logic [7:0]  CH_STRIDE     = 8'h04;
  localparam logic [7:0]  CAP_STRIDE    = 8'h08;
  localparam logic [7:0]  CAP_LO_OFS    = 8'h04;
  localparam int          BIT_FLAG      = 7;
  localparam int          BIT_IE        = 6;
  localparam int          BIT_HALT      = 5;
  localparam int          BIT_CRST      = 4;
  localparam int          SEL_MSB       = 2;
  localparam int          EDGE_LSB      = 2;
  localparam logic [2:0]  SEL_EXT       = 3'h7;
  localparam logic [2:0]  SEL_RESET     = 3'h0;
  localparam logic        HALT_RESET    = 1'h1;
  localparam logic [15:0] MOD_RESET     = 16'hffff;
  localparam logic [1:0]  EDGE_OFF      = 2'h0;
  localparam logic [1:0]  EDGE_RISE     = 2'h1;
  localparam logic [1:0]  EDGE_FALL     = 2'h2;
  localparam logic [1:0]  EDGE_ANY      = 2'h3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam int          PRESC_W       = 6;
endpackage
